// ===== sgmc_pkg.sv
// Constants, register map and field layout of the switch global MAC
// control bank. Assumes a 100 MHz core clock.
// Functional notes
// [R1] Null VID replaced by port default when enabled
// [R2] Storm rate: three high bits plus low byte
// [R3] Broadcast budget is storm rate times 64
// [R4] Storm period 5/50/500 ms by port speed
// [R5] Storm rate resets to 0x4A low, zero high
// [R6] Pass-pause bit forwards PAUSE, clear filters them
// [R7] Ingress period 16/64/256 ms, resets to 01
// [R8] Egress mode bit: per queue or per port
// [R9] Counter flush clears counters, bit self-clears
// [R10] Counter freeze holds counters while set
// [R11] Counters live per port in own window
// [R12] PCP mapped to programmable internal priority
// [R13] PCP map resets to identity
// [R14] Budget reloads each period, excess frames dropped
// [R15] Read-only reserved bits read zero
package sgmc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register slots, printed indices (byte address = 4 * index)
  localparam int NUM_REGS = 9;
  localparam int S_CTL2 = 0;
  localparam int S_CTL3 = 1;
  localparam int S_CTL4 = 2;
  localparam int S_CTL5 = 3;
  localparam int S_CNT = 4;
  localparam int S_MAP01 = 5;
  localparam int S_MAP67 = 8;
  localparam logic [9:0] REG_IDX [0:8] = '{10'h332, 10'h333, 10'h334,
    10'h335, 10'h336, 10'h338, 10'h339, 10'h33A, 10'h33B};
  // Writable bits of each register; the rest read zero
  localparam logic [7:0] REG_WMASK [0:8] = '{8'hFF, 8'hFF, 8'h01, 8'h78,
    8'hC0, 8'h77, 8'h77, 8'h77, 8'h77};
  localparam logic [7:0] STORM_LOW_RST = 8'h4A;
  localparam logic [7:0] REG_RST [0:8] = '{8'h00, STORM_LOW_RST, 8'h00,
    8'h10, 8'h00, 8'h10, 8'h32, 8'h54, 8'h76};

  ////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int NULL_VID_BIT = 3;
  localparam int PASS_PAUSE_BIT = 0;
  localparam int ING_PER_LSB = 4;
  localparam int EGR_QUEUE_BIT = 3;
  localparam int FLUSH_BIT = 7;
  localparam int FREEZE_BIT = 6;
  localparam int MAP_HI_LSB = 4;

  ////////////////////////////////////////////////////////////////////////
  // Storm budget and timing
  localparam int STORM_BW = 17;
  localparam int STORM_SHIFT = 6;
  localparam int STORM_BYTE_UNIT = 64;
  localparam logic [16:0] STORM_RST_BUDGET =
    17'(int'(STORM_LOW_RST) * STORM_BYTE_UNIT);
  localparam int CLK_PERIOD_NS = 10;
  localparam int STORM_BASE_MS = 5;
  localparam int STORM_MID_MS = 50;
  localparam int STORM_SLOW_MS = 500;
  localparam int STORM_STEP = STORM_MID_MS / STORM_BASE_MS;
  localparam int STORM_BASE_CYC = STORM_BASE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int ING_BASE_MS = 16;
  localparam int ING_MID_MS = 64;
  localparam int ING_SLOW_MS = 256;
  localparam int ING_STEP = ING_MID_MS / ING_BASE_MS;
  localparam int ING_BASE_CYC = ING_BASE_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] ING_16 = 2'h0;
  localparam logic [1:0] ING_64 = 2'h1;
  localparam logic [11:0] NULL_VID = 12'h000;

  ////////////////////////////////////////////////////////////////////////
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== sgmc_storm_if.sv
// Budget control link between the bank and one per-port storm limiter.
// Assumes both ends share one clock.
`timescale 1ns/10ps
`default_nettype none
interface sgmc_storm_if #(parameter int BW = 17);
  logic tick;
  logic [BW-1:0] budget;
  logic frame_valid;
  logic [15:0] frame_bytes;
  logic drop_valid;
  logic drop;
  modport ctrl (output tick, output budget, output frame_valid,
    output frame_bytes, input drop_valid, input drop);
  modport limiter (input tick, input budget, input frame_valid,
    input frame_bytes, output drop_valid, output drop);
endinterface
`default_nettype wire

// ===== sgmc_storm_limiter.sv
// Per-port broadcast byte budget. Assumes the bank supplies a period
// tick and the budget in bytes.
`timescale 1ns/10ps
`default_nettype none
module sgmc_storm_limiter
  import sgmc_pkg::*;
#(
  parameter int BW = STORM_BW
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Budget link
  sgmc_storm_if.limiter lim
);

  logic [BW-1:0] remaining;
  logic [BW-1:0] base;
  logic [BW-1:0] bytes;

  // A tick in the same cycle as a frame reloads first
  always_comb begin
    base = lim.tick ? lim.budget : remaining; // R14
    bytes = BW'(lim.frame_bytes);
  end

  // Oversized frames are dropped but do not drain what is left
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remaining <= STORM_RST_BUDGET;
    end else if (lim.frame_valid && bytes <= base) begin
      remaining <= base - bytes; // R3
    end else begin
      remaining <= base; // R14
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lim.drop_valid <= 1'b0;
      lim.drop <= 1'b0;
    end else begin
      lim.drop_valid <= lim.frame_valid;
      lim.drop <= lim.frame_valid && (bytes > base); // R14
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_budget_drop: assert property ( // R14
    lim.frame_valid && !lim.tick && bytes > remaining
      |=> lim.drop_valid && lim.drop)
    else $error("frame over budget not dropped");
  a_budget_reload: assert property ( // R3
    lim.tick && !lim.frame_valid |=> remaining == $past(lim.budget))
    else $error("budget not reloaded at period tick");

endmodule
`default_nettype wire

// ===== sgmc_top.sv
// Switch global MAC control bank behind an AXI4-Lite slave, with the
// per-port storm limiters and the frame classification it steers.
// Assumes synchronous frame-side inputs, one classified frame per cycle.
`timescale 1ns/10ps
`default_nettype none
module sgmc_top
  import sgmc_pkg::*;
#(
  parameter int NPORTS = 5,
  parameter int AW = 12,
  parameter int STORM_CYC = STORM_BASE_CYC,
  parameter int ING_CYC = ING_BASE_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Received VLAN tag classification
  input wire logic tag_valid,
  input wire logic [11:0] tag_vid,
  input wire logic [11:0] tag_default_vid,
  input wire logic [2:0] tag_pcp,
  output logic tag_out_valid,
  output logic [11:0] tag_out_vid,
  output logic [2:0] tag_out_prio,
  // PAUSE frame filter
  input wire logic pause_valid,
  output logic pause_out_valid,
  output logic pause_drop,
  // Broadcast storm protection, per port
  input wire logic [NPORTS-1:0][1:0] port_speed,
  input wire logic [NPORTS-1:0] bcast_valid,
  input wire logic [NPORTS-1:0][15:0] bcast_bytes,
  output logic [NPORTS-1:0] bcast_out_valid,
  output logic [NPORTS-1:0] bcast_drop,
  // Rate limiter and statistics counter control
  output logic ingress_tick,
  output logic egress_queue_mode,
  output logic stat_cnt_flush,
  output logic stat_cnt_freeze
);

  logic [7:0] regs [0:NUM_REGS-1];
  logic aw_held;
  logic w_held;
  logic [AW-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wlane_q;
  logic write_do;
  logic w_hit;
  logic [3:0] w_slot;
  logic r_hit;
  logic [3:0] r_slot;
  logic [STORM_BW-1:0] budget;

  // Address to slot; byte address is four times the printed index
  function automatic logic [4:0] decode(input logic [AW-1:0] addr);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (addr[1:0] == 2'h0 && addr[AW-1:2] == (AW-2)'(REG_IDX[i])) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel; address and data may arrive in any order
  assign write_do = aw_held && w_held && !s_axi_bvalid;
  assign {w_hit, w_slot} = decode(awaddr_q);
  assign {r_hit, r_slot} = decode(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      s_axi_awready <= 1'b1;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      s_axi_awready <= 1'b0;
      awaddr_q <= s_axi_awaddr;
    end else if (write_do) begin
      aw_held <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      s_axi_wready <= 1'b1;
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      s_axi_wready <= 1'b0;
      wdata_q <= s_axi_wdata[7:0];
      wlane_q <= s_axi_wstrb[0];
    end else if (write_do) begin
      w_held <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (write_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= w_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file; only byte lane 0 carries data
  generate
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          regs[g] <= REG_RST[g]; // R5 R13
        end else if (write_do && w_hit && wlane_q && w_slot == 4'(g)) begin
          regs[g] <= wdata_q & REG_WMASK[g]; // R15
        end else if (g == S_CNT) begin
          // Flush is a single-cycle command
          regs[g] <= regs[g] & ~(8'h01 << FLUSH_BIT); // R9
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= r_hit ? {24'h000000, regs[r_slot]} : 32'h0000_0000;
      s_axi_rresp <= r_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control levels straight from the register flops
  assign egress_queue_mode = regs[S_CTL5][EGR_QUEUE_BIT]; // R8
  assign stat_cnt_flush = regs[S_CNT][FLUSH_BIT]; // R9 R11
  assign stat_cnt_freeze = regs[S_CNT][FREEZE_BIT]; // R10 R11
  assign budget = {regs[S_CTL2][2:0], regs[S_CTL3], 6'h00}; // R2 R3

  ////////////////////////////////////////////////////////////////////////
  // Tag classification: null VID fix-up and PCP priority lookup
  logic [7:0] map_byte;
  assign map_byte = regs[S_MAP01 + 32'(tag_pcp[2:1])];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tag_out_valid <= 1'b0;
      tag_out_vid <= NULL_VID;
      tag_out_prio <= 3'h0;
    end else begin
      tag_out_valid <= tag_valid;
      if (regs[S_CTL2][NULL_VID_BIT] && tag_vid == NULL_VID) begin
        tag_out_vid <= tag_default_vid; // R1
      end else begin
        tag_out_vid <= tag_vid;
      end
      tag_out_prio <= tag_pcp[0] ? map_byte[MAP_HI_LSB +: 3]
                                 : map_byte[2:0]; // R12
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pause_out_valid <= 1'b0;
      pause_drop <= 1'b0;
    end else begin
      pause_out_valid <= pause_valid;
      pause_drop <= pause_valid && !regs[S_CTL4][PASS_PAUSE_BIT]; // R6
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Period ticks; slower periods are decades of the 5 ms base, so the
  // wide counter exists once rather than per port
  logic [31:0] storm_cnt;
  logic [3:0] storm_mid_cnt;
  logic [3:0] storm_slow_cnt;
  logic tick_fast;
  logic tick_mid;
  logic tick_slow;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      storm_cnt <= 32'h0000_0000;
      tick_fast <= 1'b0;
    end else begin
      tick_fast <= storm_cnt == 32'(STORM_CYC - 1);
      storm_cnt <= (storm_cnt == 32'(STORM_CYC - 1)) ? 32'h0000_0000
                                                     : storm_cnt + 32'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      storm_mid_cnt <= 4'h0;
      storm_slow_cnt <= 4'h0;
      tick_mid <= 1'b0;
      tick_slow <= 1'b0;
    end else begin
      tick_mid <= tick_fast && storm_mid_cnt == 4'(STORM_STEP - 1);
      tick_slow <= tick_mid && storm_slow_cnt == 4'(STORM_STEP - 1);
      if (tick_fast) begin
        storm_mid_cnt <= (storm_mid_cnt == 4'(STORM_STEP - 1)) ? 4'h0
                                                : storm_mid_cnt + 4'h1;
      end
      if (tick_mid) begin
        storm_slow_cnt <= (storm_slow_cnt == 4'(STORM_STEP - 1)) ? 4'h0
                                                : storm_slow_cnt + 4'h1;
      end
    end
  end

  // Ingress period ticks, built the same way in steps of four
  logic [31:0] ing_cnt;
  logic [1:0] ing_mid_cnt;
  logic [1:0] ing_slow_cnt;
  logic ing_fast;
  logic ing_mid;
  logic ing_slow;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ing_cnt <= 32'h0000_0000;
      ing_fast <= 1'b0;
      ing_mid <= 1'b0;
      ing_slow <= 1'b0;
      ing_mid_cnt <= 2'h0;
      ing_slow_cnt <= 2'h0;
    end else begin
      ing_fast <= ing_cnt == 32'(ING_CYC - 1);
      ing_cnt <= (ing_cnt == 32'(ING_CYC - 1)) ? 32'h0000_0000
                                               : ing_cnt + 32'h1;
      ing_mid <= ing_fast && ing_mid_cnt == 2'(ING_STEP - 1);
      ing_slow <= ing_mid && ing_slow_cnt == 2'(ING_STEP - 1);
      if (ing_fast) begin
        ing_mid_cnt <= ing_mid_cnt + 2'h1;
      end
      if (ing_mid) begin
        ing_slow_cnt <= ing_slow_cnt + 2'h1;
      end
    end
  end

  logic [1:0] ing_sel;
  assign ing_sel = regs[S_CTL5][ING_PER_LSB +: 2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ingress_tick <= 1'b0;
    end else if (ing_sel == ING_16) begin
      ingress_tick <= ing_fast; // R7
    end else if (ing_sel == ING_64) begin
      ingress_tick <= ing_mid; // R7
    end else begin
      ingress_tick <= ing_slow; // R7
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-port storm limiters
  generate
    for (genvar p = 0; p < NPORTS; p++) begin : g_port
      sgmc_storm_if #(.BW(STORM_BW)) link ();
      assign link.tick = (port_speed[p] == SPD_10) ? tick_slow
                       : (port_speed[p] == SPD_100) ? tick_mid
                       : tick_fast; // R4
      assign link.budget = budget;
      assign link.frame_valid = bcast_valid[p];
      assign link.frame_bytes = bcast_bytes[p];
      assign bcast_out_valid[p] = link.drop_valid;
      assign bcast_drop[p] = link.drop;
      sgmc_storm_limiter #(.BW(STORM_BW)) u_lim (
        .aclk(aclk),
        .aresetn(aresetn),
        .lim(link)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_flush_write;
    write_do && w_hit && wlane_q && w_slot == 4'(S_CNT) && wdata_q[FLUSH_BIT];
  endsequence
  sequence s_flush_pulse;
    stat_cnt_flush ##1 !stat_cnt_flush;
  endsequence

  a_null_vid_fix: assert property ( // R1
    tag_valid && tag_vid == NULL_VID && regs[S_CTL2][NULL_VID_BIT]
      |=> tag_out_valid && tag_out_vid == $past(tag_default_vid))
    else $error("null VID not replaced");
  a_vid_keep: assert property ( // R1
    tag_valid && !(tag_vid == NULL_VID && regs[S_CTL2][NULL_VID_BIT])
      |=> tag_out_vid == $past(tag_vid))
    else $error("VID altered");
  a_storm_budget: assert property ( // R2
    budget == STORM_BW'({regs[S_CTL2][2:0], regs[S_CTL3]}) * 17'h00040)
    else $error("storm budget mismatch");
  a_storm_reset: assert property ( // R5
    $past(!aresetn) |-> regs[S_CTL3] == 8'h4A && regs[S_CTL2][2:0] == 3'h0)
    else $error("storm rate reset value wrong");
  a_pause_filter: assert property ( // R6
    pause_valid |=> pause_out_valid
      && pause_drop == !$past(regs[S_CTL4][PASS_PAUSE_BIT]))
    else $error("PAUSE decision wrong");
  a_ing_slow: assert property ( // R7
    ing_sel[1] && $stable(ing_sel) |=> ingress_tick == $past(ing_slow))
    else $error("ingress 256 ms period not selected");
  a_flush_pulse: assert property ( // R9
    s_flush_write |=> s_flush_pulse)
    else $error("flush did not self-clear after one cycle");
  a_pcp_map: assert property ( // R12
    tag_valid && tag_pcp == 3'h5
      |=> tag_out_prio == $past(regs[S_MAP01 + 2][6:4]))
    else $error("PCP lookup wrong");
  a_pcp_reset: assert property ( // R13
    $past(!aresetn) |-> regs[S_MAP01] == 8'h10 && regs[S_MAP67] == 8'h76)
    else $error("PCP map not identity after reset");
  a_rsv_zero: assert property ( // R15
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000
      && (regs[S_CTL4] & 8'hFE) == 8'h00)
    else $error("reserved bits not zero");

endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the global MAC control bank.
// Assumes a single 100 MHz clock and AXI4-Lite register access.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sgmc_pkg::*;
  typedef struct {string nm; logic [33:0] v;} sgmc_exp_t;
  localparam int ING = 8;
  logic aclk, aresetn;
  logic [11:0] awaddr, araddr, tvid, tdef, tovid;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic tv, tov, pv, pov, pdrop, itick, eqm, flush, frz;
  logic [2:0] tpcp, toprio;
  logic [4:0][1:0] spd;
  logic [4:0] bv, bov, bdrop;
  logic [4:0][15:0] bb;
  logic [7:0] regs [0:8];
  logic [7:0] d;
  sgmc_exp_t q[$];
  int miscompares, total_checks, nflush, n0;
  int acc [0:4];

  sgmc_top #(.STORM_CYC(20), .ING_CYC(ING)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tag_valid(tv), .tag_vid(tvid), .tag_default_vid(tdef),
    .tag_pcp(tpcp), .tag_out_valid(tov), .tag_out_vid(tovid),
    .tag_out_prio(toprio), .pause_valid(pv), .pause_out_valid(pov),
    .pause_drop(pdrop), .port_speed(spd), .bcast_valid(bv),
    .bcast_bytes(bb), .bcast_out_valid(bov), .bcast_drop(bdrop),
    .ingress_tick(itick), .egress_queue_mode(eqm),
    .stat_cnt_flush(flush), .stat_cnt_freeze(frz)
  );

  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Reporting
  task automatic results();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic hang();
    miscompares++;
    results();
  endtask

  task automatic chk(string nm, logic [33:0] e, logic [33:0] s);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Output watcher: every result except ports 1..4 broadcast takes the oldest note; those only count passes
  task automatic take(logic [33:0] s);
    sgmc_exp_t e;
    e.nm = "spurious";
    e.v = 'x;
    if (q.size() > 0) e = q.pop_front();
    chk(e.nm, e.v, s);
  endtask

  always @(posedge aclk) begin
    if (aresetn) begin
      if (bvalid && bready) take({bresp, 32'h0});
      if (rvalid && rready) take({rresp, rdata});
      if (tov) take({19'h0, tovid, toprio});
      if (pov) take({33'h0, pdrop});
      if (bov[0]) take({33'h0, bdrop[0]});
      for (int p = 1; p < 5; p++) if (bov[p] && !bdrop[p]) acc[p]++;
      if (flush === 1'b1) nflush++;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Drivers; a task waits one edge first so no signal is set twice
  task automatic wr(logic [11:0] a, logic [7:0] v, logic [1:0] r);
    @(posedge aclk);
    q.push_back('{"bresp", {r, 32'h0}});
    awaddr <= a;
    wdata <= {24'($urandom()), v};
    wstrb <= 4'h1;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (int i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid && bready) begin
        bready <= 0;
        return;
      end
    end
    hang();
  endtask

  task automatic rd(logic [11:0] a, logic [33:0] e);
    @(posedge aclk);
    q.push_back('{"rdata", e});
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (int i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid && rready) begin
        rready <= 0;
        return;
      end
    end
    hang();
  endtask

  // Flush reads back as zero once it has cleared itself
  task automatic set(int i, logic [7:0] v);
    wr({REG_IDX[i], 2'b00}, v, RESP_OKAY);
    regs[i] = v & REG_WMASK[i] & ((i == S_CNT) ? 8'h7F : 8'hFF);
  endtask

  task automatic frame(logic [15:0] n, bit drop);
    @(posedge aclk);
    q.push_back('{"bcast_drop", {33'h0, drop}});
    bv[0] <= 1;
    bb[0] <= n;
    @(posedge aclk);
    bv[0] <= 0;
  endtask

  task automatic tag(logic [11:0] vid, logic [2:0] pcp);
    logic [7:0] m;
    logic [11:0] dv, ev;
    m = regs[S_MAP01 + pcp / 2];
    dv = 12'($urandom());
    ev = (regs[S_CTL2][NULL_VID_BIT] && vid == NULL_VID) ? dv : vid;
    @(posedge aclk);
    q.push_back('{"tag_out", {19'h0, ev, pcp[0] ? m[6:4] : m[2:0]}});
    tdef <= dv;
    tvid <= vid;
    tpcp <= pcp;
    tv <= 1;
    @(posedge aclk);
    tv <= 0;
  endtask

  task automatic pause();
    @(posedge aclk);
    q.push_back('{"pause_drop", {33'h0, !regs[S_CTL4][PASS_PAUSE_BIT]}});
    pv <= 1;
    @(posedge aclk);
    pv <= 0;
  endtask

  // Measures the second gap between ingress ticks, after settling
  task automatic per(int e);
    int n;
    n = 0;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      @(posedge aclk);
      while (itick !== 1'b1 && n < 300) begin
        @(posedge aclk);
        n++;
      end
      if (n == 300) hang();
    end
    chk("ingress_period", e, n + 1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, tv, tvid, tdef, tpcp, pv} = '0;
    spd = '0;
    bv = '0;
    bb = '0;
    regs = '{8'h00, 8'h4A, 8'h00, 8'h10, 8'h00, 8'h10, 8'h32, 8'h54, 8'h76};
    miscompares = 0;
    total_checks = 0;
    nflush = 0;
    void'($urandom(32'h0D2D));
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    // Reset budget is 0x4A * 64 = 4736 bytes; no reload for 2000 cycles
    repeat (4) frame(16'd1000, 0);
    frame(16'd1000, 1);
    frame(16'd736, 0);
    frame(16'd1, 1);
    for (int i = 0; i < NUM_REGS; i++) begin
      rd({REG_IDX[i], 2'b00}, {RESP_OKAY, 24'h0, regs[i]});
    end
    rd(12'hCDC, {RESP_SLVERR, 32'h0});
    wr(12'hCDC, 8'hFF, RESP_SLVERR);
    per(4 * ING);
    for (int p = 0; p < 2; p++) begin
      n0 = nflush;
      for (int i = 0; i < NUM_REGS; i++) begin
        d = p ? ~regs[i] : 8'($urandom());
        if (i == S_CNT) n0 += d[FLUSH_BIT];
        set(i, d);
        rd({REG_IDX[i], 2'b00}, {RESP_OKAY, 24'h0, regs[i]});
      end
      chk("flush_count", n0, nflush);
      chk("freeze", regs[S_CNT][FREEZE_BIT], frz);
      chk("egress_mode", regs[S_CTL5][EGR_QUEUE_BIT], eqm);
      for (int c = 0; c < 8; c++) begin
        tag(NULL_VID, 3'(c));
        tag(12'($urandom()) | 12'h001, 3'(c));
      end
      pause();
    end
    for (int c = 0; c < 4; c++) begin
      set(S_CTL5, 8'(c << ING_PER_LSB));
      per(ING * ((c == 0) ? 1 : (c == 1) ? 4 : 16));
    end
    // One 64-byte frame per period: ports 1..4 at 10M, 100M, 1000M, 10M
    set(S_CTL2, 8'h00);
    set(S_CTL3, 8'h01);
    spd <= 10'h090;
    repeat (2100) @(posedge aclk);
    acc = '{0, 0, 0, 0, 0};
    bb[4:1] <= {4{16'd64}};
    bv[4:1] <= 4'hF;
    repeat (400) @(posedge aclk);
    bv[4:1] <= 4'h0;
    repeat (4) @(posedge aclk);
    chk("storm_10m", 1, acc[1] inside {[1:2]});
    chk("storm_100m", 1, acc[2] inside {[2:3]});
    chk("storm_1000m", 1, acc[3] inside {[20:21]});
    chk("storm_10m_p4", 1, acc[4] inside {[1:2]});
    chk("notes_left", 0, q.size());
    results();
  end
endmodule
`default_nettype wire
